/* File: design/uab_pkg.sv */
// Constants shared by the serial port core and its receive buffer.
// Assumes a single 250 MHz system clock.
package uab_pkg;
    // Control register bit positions
    localparam int CTL_MODE_BIT = 7;
    localparam int CTL_MCE_BIT = 5;
    localparam int CTL_REN_BIT = 4;
    localparam int CTL_TB8_BIT = 3;
    localparam int CTL_RB8_BIT = 2;
    localparam int CTL_TI_BIT = 1;
    localparam int CTL_RI_BIT = 0;
    localparam logic [7:0] CTL_RESET = 8'h40;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Timer and divider constants
    localparam logic [8:0] TIMER_SPAN = 9'h100;
    localparam logic [2:0] SRC_SYS = 3'h0;
    localparam logic [2:0] SRC_DIV4 = 3'h1;
    localparam logic [2:0] SRC_DIV12 = 3'h2;
    localparam logic [2:0] SRC_DIV48 = 3'h3;
    localparam logic [2:0] SRC_EXT8 = 3'h4;
    localparam logic [2:0] SRC_PIN = 3'h5;
    localparam logic [5:0] DIV4_LAST = 6'h03;
    localparam logic [5:0] DIV12_LAST = 6'h0B;
    localparam logic [5:0] DIV48_LAST = 6'h2F;
    localparam logic [2:0] EXT8_LAST = 3'h7;
    // Bit slot counts per frame after the start bit (data, ninth and stop)
    localparam logic [3:0] BITS_8 = 4'h9;
    localparam logic [3:0] BITS_9 = 4'hA;
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} uab_tx_state_type;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} uab_rx_state_type;
endpackage

/* File: design/uab_rx_holding.sv */
// Receive holding register: the buffered receive byte; the ninth bit stays in the core's rb8.
// Assumes load pulses come from the core's receive accept logic.
`timescale 1ns/1ns
module uab_rx_holding
    import uab_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Load side
    input wire logic load_i,
    input wire logic [7:0] data_i,
    // Read side
    output logic [7:0] data_o
);
    typedef struct packed
    {
        logic [7:0] data;
    } uab_hold_type;
    uab_hold_type st_reg;
    uab_hold_type st_next;

    // Load only on an accepted character
    always_comb
    begin
        st_next = st_reg;
        if (load_i)
        begin
            st_next.data = data_i;
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_reg <= '{data: DATA_RESET};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign data_o = st_reg.data;
endmodule

/* File: design/uab_uart.sv */
// Full-duplex serial port with 8/9-bit frames and timer-based baud clock.
// Assumes a CPU-side register port of strobes on the same clock.
`timescale 1ns/1ns
module uab_uart
    import uab_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Data buffer access
    input wire logic data_write_i,
    input wire logic [7:0] data_wdata_i,
    output logic [7:0] data_rdata_o,
    // Control register access
    input wire logic ctl_write_i,
    input wire logic [7:0] ctl_wdata_i,
    output logic [7:0] serial_control_reg_o,
    // Timer 1 setup
    input wire logic timer1_run_i,
    input wire logic [2:0] timer1_source_i,
    input wire logic [7:0] timer1_reload_byte_i,
    output logic [7:0] timer1_low_count_o,
    // Interrupt enable and request
    input wire logic int_enable_i,
    output logic int_o,
    // Pins
    input wire logic ext_osc_i,
    input wire logic timer1_external_input_i,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o
);
    typedef struct packed
    {
        logic [2:0] sync_rx;
        logic [2:0] sync_osc;
        logic [2:0] sync_t1;
        logic [5:0] pre_cnt;
        logic [2:0] osc_cnt;
        logic [7:0] tx_timer;
        logic [7:0] rx_timer;
        logic tx_half;
        logic rx_half;
        logic mode9;
        logic mce;
        logic ren;
        logic tb8;
        logic rb8;
        logic ti;
        logic ri;
        uab_tx_state_type tx_state;
        logic [8:0] tx_shift;
        logic [3:0] tx_cnt;
        logic tx_pin;
        uab_rx_state_type rx_state;
        logic [8:0] rx_shift;
        logic [3:0] rx_cnt;
        logic rx_prev;
    } uab_state_type;
    uab_state_type st_reg;
    uab_state_type st_next;
    logic rx_load;
    logic [7:0] rx_load_data;

    // Receive holding register, read through the data buffer
    uab_rx_holding u_hold
    (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .load_i(rx_load),
        .data_i(rx_load_data),
        .data_o(data_rdata_o)
    );

    // Whole next-state computation
    always_comb
    begin
        logic tick;
        logic tx_ovf;
        logic rx_ovf;
        logic tx_bit;
        logic rx_bit;
        logic rx_in;
        logic start_seen;
        logic accept;
        logic [3:0] last_slot;
        tick = 1'b0;
        tx_ovf = 1'b0;
        rx_ovf = 1'b0;
        tx_bit = 1'b0;
        rx_bit = 1'b0;
        accept = 1'b0;
        rx_in = st_reg.sync_rx[1];
        start_seen = st_reg.rx_prev && !st_reg.sync_rx[1];
        st_next = st_reg;
        rx_load = 1'b0;
        rx_load_data = st_reg.rx_shift[7:0];
        last_slot = st_reg.mode9 ? BITS_9 : BITS_8;
        // Pin synchronisers; only stage 1 and up are read
        st_next.sync_rx = {st_reg.sync_rx[1:0], serial_in_pin_i};
        st_next.sync_osc = {st_reg.sync_osc[1:0], ext_osc_i};
        st_next.sync_t1 = {st_reg.sync_t1[1:0], timer1_external_input_i};
        // Timer clock source selection
        st_next.pre_cnt = st_reg.pre_cnt + 6'h01;
        if (st_reg.sync_osc[1] && !st_reg.sync_osc[2])
        begin
            st_next.osc_cnt = st_reg.osc_cnt + 3'h1;
        end
        case (timer1_source_i)
            SRC_SYS: tick = 1'b1;
            SRC_DIV4: tick = (st_reg.pre_cnt[1:0] == DIV4_LAST[1:0]);
            // Four evenly spaced ticks per 48-clock prescaler lap
            SRC_DIV12: tick = ((st_reg.pre_cnt % (DIV12_LAST + 6'h01))
                == DIV12_LAST);
            SRC_DIV48: tick = (st_reg.pre_cnt == DIV48_LAST);
            SRC_EXT8: tick = st_reg.sync_osc[1] && !st_reg.sync_osc[2]
                && (st_reg.osc_cnt == EXT8_LAST);
            SRC_PIN: tick = !st_reg.sync_t1[1] && st_reg.sync_t1[2];
            default: tick = 1'b0;
        endcase
        if (st_reg.pre_cnt == DIV48_LAST)
        begin
            st_next.pre_cnt = 6'h00;
        end
        // Auto-reload transmit timer and hidden receive copy
        if (timer1_run_i && tick)
        begin
            tx_ovf = (st_reg.tx_timer == 8'hFF);
            rx_ovf = (st_reg.rx_timer == 8'hFF);
            // Period is 256 minus reload ticks
            st_next.tx_timer = tx_ovf ? timer1_reload_byte_i
                : st_reg.tx_timer + 8'h01;
            st_next.rx_timer = rx_ovf ? timer1_reload_byte_i
                : st_reg.rx_timer + 8'h01;
        end
        // Overflows halved into bit ticks
        if (tx_ovf)
        begin
            st_next.tx_half = !st_reg.tx_half;
            tx_bit = st_reg.tx_half;
        end
        if (rx_ovf)
        begin
            st_next.rx_half = !st_reg.rx_half;
            rx_bit = st_reg.rx_half;
        end
        // Control register writes; done flags only cleared by software
        if (ctl_write_i)
        begin
            st_next.mode9 = ctl_wdata_i[CTL_MODE_BIT];
            st_next.mce = ctl_wdata_i[CTL_MCE_BIT];
            st_next.ren = ctl_wdata_i[CTL_REN_BIT];
            st_next.tb8 = ctl_wdata_i[CTL_TB8_BIT];
            st_next.rb8 = ctl_wdata_i[CTL_RB8_BIT];
            st_next.ti = ctl_wdata_i[CTL_TI_BIT];
            st_next.ri = ctl_wdata_i[CTL_RI_BIT];
        end
        // Transmitter
        case (st_reg.tx_state)
            TX_IDLE:
            begin
                st_next.tx_pin = 1'b1;
                if (data_write_i)
                begin
                    // Ninth slot carries tb8 in 9-bit mode, else idle high
                    st_next.tx_shift = {(st_reg.mode9 ? st_reg.tb8 : 1'b1),
                        data_wdata_i};
                    st_next.tx_state = TX_START;
                end
            end
            TX_START:
            begin
                if (tx_bit)
                begin
                    st_next.tx_pin = 1'b0;
                    st_next.tx_cnt = 4'h0;
                    st_next.tx_state = TX_DATA;
                end
            end
            TX_DATA:
            begin
                if (tx_bit)
                begin
                    st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
                    if (st_reg.tx_cnt == last_slot - 4'h1)
                    begin
                        st_next.tx_pin = 1'b1;
                        st_next.ti = 1'b1;
                        st_next.tx_state = TX_STOP;
                    end
                    else
                    begin
                        // LSB first, ninth bit last in 9-bit mode
                        st_next.tx_pin = st_reg.tx_shift[0];
                        st_next.tx_shift = {1'b1, st_reg.tx_shift[8:1]};
                    end
                end
            end
            TX_STOP:
            begin
                if (tx_bit)
                begin
                    st_next.tx_state = TX_IDLE;
                end
            end
            default: st_next.tx_state = TX_IDLE;
        endcase
        // Receiver
        st_next.rx_prev = rx_in;
        case (st_reg.rx_state)
            RX_IDLE:
            begin
                if (start_seen && st_reg.ren && timer1_run_i)
                begin
                    st_next.rx_timer = timer1_reload_byte_i;
                    st_next.rx_half = 1'b0;
                    st_next.rx_cnt = 4'h0;
                    st_next.rx_state = RX_START;
                end
            end
            RX_START:
            begin
                // First halved tick lands mid start bit
                if (rx_ovf && !st_reg.rx_half)
                begin
                    st_next.rx_state = rx_in ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA:
            begin
                if (rx_ovf && !st_reg.rx_half)
                begin
                    st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
                    if (st_reg.rx_cnt == last_slot - 4'h1)
                    begin
                        st_next.rx_state = RX_STOP;
                    end
                    // 9-bit stop sample is dropped so bit 0 is kept
                    if (!st_reg.mode9 || st_reg.rx_cnt != last_slot - 4'h1)
                    begin
                        st_next.rx_shift = {rx_in, st_reg.rx_shift[8:1]};
                    end
                end
            end
            RX_STOP:
            begin
                // Bit 8 is the stop bit, or the ninth bit in 9-bit mode
                if (st_reg.mode9)
                begin
                    accept = st_reg.ren && !st_reg.ri
                        && (!st_reg.mce || st_reg.rx_shift[8]);
                end
                else
                begin
                    accept = st_reg.ren && !st_reg.ri
                        && (!st_reg.mce || st_reg.rx_shift[8]);
                end
                // Overrun: held byte kept, new one dropped
                if (accept)
                begin
                    rx_load = 1'b1;
                    st_next.rb8 = st_reg.rx_shift[8];
                    st_next.ri = 1'b1;
                end
                st_next.rx_state = RX_IDLE;
            end
            default: st_next.rx_state = RX_IDLE;
        endcase
        if (!st_reg.ren)
        begin
            st_next.rx_state = RX_IDLE;
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_reg <= '0;
            st_reg.sync_rx <= 3'h7;
            st_reg.rx_prev <= 1'b1;
            st_reg.tx_pin <= 1'b1;
            st_reg.tx_shift <= 9'h1FF;
            st_reg.tx_state <= TX_IDLE;
            st_reg.rx_state <= RX_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign serial_out_pin_o = st_reg.tx_pin;
    assign timer1_low_count_o = st_reg.tx_timer;
    assign serial_control_reg_o = {st_reg.mode9, CTL_RESET[6], st_reg.mce,
        st_reg.ren, st_reg.tb8, st_reg.rb8, st_reg.ti, st_reg.ri};
    assign int_o = int_enable_i && (st_reg.ti || st_reg.ri);
endmodule

/* File: tb/testbench.sv */
// Bench: drives the serial port core against a remote peer model.
// Assumes the peer model and the bound checker are compiled first.
`timescale 1ns/1ns
module testbench
    import uab_pkg::*;
;
    localparam logic [7:0] RELOAD = 8'hFC;
    localparam int BIT_T = 2 * (256 - int'(RELOAD));
    // Flag wait covers the first full timer lap after reset
    localparam int WAIT_MAX = 512 + 40 * BIT_T;
    // Clocks per timer tick; the two pin sources see a 4-clock wave
    localparam int DIVS [6] = '{1, 4, 12, 48, 32, 4};
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic data_write_i = 1'b0;
    logic ctl_write_i = 1'b0;
    logic [7:0] data_wdata_i = 8'h00;
    logic [7:0] ctl_wdata_i = 8'h00;
    logic timer1_run_i = 1'b1;
    logic int_en = 1'b1;
    logic nine = 1'b0;
    logic [2:0] src = SRC_SYS;
    logic [7:0] reload = RELOAD;
    logic ext_pin = 1'b0;
    logic rx_line, tx_line, int_o;
    logic [7:0] rdata, ctl_o, count, peer_data, peer_tail, c0;
    int error_cnt = 0;
    int tests_run = 0;

    // 250 MHz clock
    initial forever #2 clock_i = ~clock_i;

    // Square wave for the oscillator and count pin sources
    initial
    begin
        forever
        begin
            repeat (2) @(negedge clock_i);
            ext_pin = ~ext_pin;
        end
    end

    uab_uart u_dut (
        .clock_i(clock_i), .resetn_i(resetn_i),
        .data_write_i(data_write_i), .data_wdata_i(data_wdata_i),
        .data_rdata_o(rdata), .ctl_write_i(ctl_write_i),
        .ctl_wdata_i(ctl_wdata_i), .serial_control_reg_o(ctl_o),
        .timer1_run_i(timer1_run_i), .timer1_source_i(src),
        .timer1_reload_byte_i(reload), .timer1_low_count_o(count),
        .int_enable_i(int_en), .int_o(int_o), .ext_osc_i(ext_pin),
        .timer1_external_input_i(ext_pin), .serial_in_pin_i(rx_line),
        .serial_out_pin_o(tx_line)
    );
    uab_peer_model #(.BIT_CLKS(BIT_T)) u_peer (
        .clock_i(clock_i), .nine_i(nine), .line_i(tx_line),
        .line_o(rx_line), .rx_data_o(peer_data), .rx_tail_o(peer_tail)
    );

    // Compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Print counts and verdict, then end
    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One-cycle write strobe to control or data
    task automatic wr(input logic ctl, input logic [7:0] v);
        @(negedge clock_i);
        ctl_wdata_i = v;
        data_wdata_i = v;
        ctl_write_i = ctl;
        data_write_i = !ctl;
        @(negedge clock_i);
        ctl_write_i = 1'b0;
        data_write_i = 1'b0;
    endtask
    // Bounded wait for a control flag
    task automatic wait_flag(input int b);
        int i;
        i = 0;
        while (ctl_o[b] !== 1'b1)
        begin
            if (i == WAIT_MAX)
            begin
                error_cnt++;
                report_and_stop();
            end
            i++;
            @(negedge clock_i);
        end
    endtask
    // Send a byte, let the stop bit finish
    task automatic tx(input logic [7:0] d);
        wr(1'b0, d);
        wait_flag(CTL_TI_BIT);
        repeat (BIT_T) @(negedge clock_i);
    endtask
    // Peer sends a frame; wait for acceptance or let it pass
    task automatic recv(input logic [7:0] d, input logic b9, input logic stp,
                        input logic take);
        u_peer.send(d, b9, stp);
        if (take)
            wait_flag(CTL_RI_BIT);
        else
            repeat (4 * BIT_T) @(negedge clock_i);
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(negedge clock_i);
        resetn_i = 1'b1;
        check(ctl_o, CTL_RESET);
        check(rdata, DATA_RESET);
        wr(1'b1, 8'h10);
        tx(8'hA5);
        check(peer_data, 8'hA5);
        check(peer_tail, 8'h01);
        check(ctl_o, 8'h52);
        check({7'h00, int_o}, 8'h01);
        int_en = 1'b0;
        @(negedge clock_i);
        check({7'h00, int_o}, 8'h00);
        int_en = 1'b1;
        wr(1'b1, 8'h10);
        recv(8'h3C, 1'b0, 1'b1, 1'b1);
        check(rdata, 8'h3C);
        check(ctl_o, 8'h55);
        recv(8'h77, 1'b0, 1'b1, 1'b0);
        check(rdata, 8'h3C);
        check(ctl_o, 8'h55);
        wr(1'b1, 8'h30);
        recv(8'h66, 1'b0, 1'b0, 1'b0);
        check(ctl_o, 8'h70);
        nine = 1'b1;
        wr(1'b1, 8'hB8);
        tx(8'h5A);
        check(peer_data, 8'h5A);
        check(peer_tail, 8'h03);
        wr(1'b1, 8'hB8);
        recv(8'h11, 1'b0, 1'b1, 1'b0);
        check(ctl_o, 8'hF8);
        recv(8'h22, 1'b1, 1'b1, 1'b1);
        check(rdata, 8'h22);
        check(ctl_o, 8'hFD);
        wr(1'b1, 8'h90);
        recv(8'h33, 1'b0, 1'b0, 1'b1);
        check(rdata, 8'h33);
        check(ctl_o, 8'hD1);
        wr(1'b1, 8'h80);
        recv(8'h44, 1'b0, 1'b1, 1'b0);
        check(ctl_o, 8'hC0);
        reload = 8'h00;
        for (int i = 0; i < 6; i++)
        begin
            src = 3'(i);
            repeat (8) @(negedge clock_i);
            c0 = count;
            repeat (96) @(negedge clock_i);
            c0 = count - c0;
            check(c0, 8'(96 / DIVS[i]));
        end
        timer1_run_i = 1'b0;
        repeat (4) @(negedge clock_i);
        c0 = count;
        repeat (40) @(negedge clock_i);
        check(count, c0);
        report_and_stop();
    end
endmodule

/* File: tb/uab_peer_model.sv */
// Remote serial peer: sends frames on request, records frames heard.
// Assumes an idle-high line and BIT_CLKS system clocks per bit.
`timescale 1ns/1ns
module uab_peer_model
#(
    parameter int BIT_CLKS = 8
)
(
    // Clock and frame width
    input wire logic clock_i,
    input wire logic nine_i,
    // Lines
    input wire logic line_i,
    output logic line_o,
    // Last frame heard
    output logic [7:0] rx_data_o,
    output logic [7:0] rx_tail_o
);
    logic [9:0] word;
    initial line_o = 1'b1;
    // Hold one bit level for a full bit time
    task automatic put(input logic v);
        line_o = v;
        repeat (BIT_CLKS) @(negedge clock_i);
    endtask
    // Start, data LSB first, optional ninth, then stop level
    task automatic send(input logic [7:0] d, input logic b9, input logic stp);
        @(negedge clock_i);
        put(1'b0);
        for (int i = 0; i < 8; i++)
            put(d[i]);
        if (nine_i)
            put(b9);
        put(stp);
        line_o = 1'b1;
    endtask
    // Sample mid-bit after each falling start edge
    initial
    begin
        forever
        begin
            @(negedge line_i);
            repeat (BIT_CLKS / 2) @(posedge clock_i);
            for (int i = 0; i < (nine_i ? 10 : 9); i++)
            begin
                repeat (BIT_CLKS) @(posedge clock_i);
                word = {line_i, word[9:1]};
            end
            if (!nine_i)
                word = {word[9], 1'b0, word[8:1]};
            rx_data_o = word[7:0];
            rx_tail_o = {6'h00, word[8], word[9]};
        end
    end
endmodule

/* File: tb/uab_uart_props.sv */
// Checker: port-level timing relations of the serial port core.
// Assumes it is bound to uab_uart; one clock domain.
`timescale 1ns/1ns
module uab_uart_props
    import uab_pkg::*;
(
    // Clock, reset and controls
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ctl_write_i,
    input wire logic timer1_run_i,
    input wire logic [2:0] timer1_source_i,
    input wire logic [7:0] timer1_reload_byte_i,
    input wire logic int_enable_i,
    // Observed outputs
    input wire logic [7:0] data_rdata_o,
    input wire logic [7:0] serial_control_reg_o,
    input wire logic [7:0] timer1_low_count_o,
    input wire logic int_o,
    input wire logic serial_out_pin_o
);
    // Flag taps and timer condition
    wire logic ti = serial_control_reg_o[CTL_TI_BIT];
    wire logic ri = serial_control_reg_o[CTL_RI_BIT];
    wire logic sys_run = timer1_run_i && (timer1_source_i == SRC_SYS);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // Flags, buffer and line
    a_int_from_flags: assert property (
        int_o == (int_enable_i && (ti || ri)))
        else $error("interrupt does not follow flags");
    a_ti_stays_set: assert property (ti && !ctl_write_i |=> ti)
        else $error("transmit flag cleared by hardware");
    a_ri_stays_set: assert property (ri && !ctl_write_i |=> ri)
        else $error("receive flag cleared by hardware");
    a_full_buffer_held: assert property (
        ri |=> $stable(data_rdata_o))
        else $error("receive buffer changed while full");
    a_buffer_sets_flag: assert property (
        $changed(data_rdata_o) |-> ri)
        else $error("buffer loaded without receive flag");
    a_ninth_with_flag: assert property (
        $changed(serial_control_reg_o[CTL_RB8_BIT])
        && !$past(ctl_write_i) |-> ri)
        else $error("ninth bit loaded without receive flag");
    a_rx_off_quiet: assert property (
        !serial_control_reg_o[CTL_REN_BIT] && !ri && !ctl_write_i |=> !ri)
        else $error("frame accepted while receiver off");
    a_stop_is_high: assert property (
        $rose(ti) && !$past(ctl_write_i) |-> ##1 serial_out_pin_o [*2])
        else $error("stop bit not high after transmit flag");
    // Timer count
    a_timer_halted: assert property (
        !timer1_run_i [*2] |=> $stable(timer1_low_count_o))
        else $error("timer moved while stopped");
    a_timer_reloads: assert property (
        sys_run && $past(sys_run) && timer1_low_count_o == 8'hFF
        |=> timer1_low_count_o == $past(timer1_reload_byte_i))
        else $error("timer did not reload on overflow");
    a_timer_steps: assert property (
        sys_run && $past(sys_run) && timer1_low_count_o != 8'hFF
        |=> timer1_low_count_o == $past(timer1_low_count_o) + 8'h01)
        else $error("timer did not count system clock");
    // Main scenarios
    c_tx_done: cover property ($rose(ti));
    c_rx_done: cover property ($rose(ri));
    c_rx_nine: cover property (ri && serial_control_reg_o[CTL_MODE_BIT]);
endmodule

bind uab_uart uab_uart_props u_props (
    .clock_i(clock_i), .resetn_i(resetn_i), .ctl_write_i(ctl_write_i),
    .timer1_run_i(timer1_run_i), .timer1_source_i(timer1_source_i),
    .timer1_reload_byte_i(timer1_reload_byte_i),
    .int_enable_i(int_enable_i), .data_rdata_o(data_rdata_o),
    .serial_control_reg_o(serial_control_reg_o),
    .timer1_low_count_o(timer1_low_count_o), .int_o(int_o),
    .serial_out_pin_o(serial_out_pin_o)
);
